// file: logic/phone_mcu_io_ports.sv
// Overview of operation
// RL1 - each port A pin may wake device
// RL2 - per-pin software direction, output or input
// RL3 - ports A and C pull-high per pin; port C bits 2,3 get no pull-high here
// RL4 - port D pull-high per four-bit nibble
// RL5 - port E pull-high one setting all
// RL6 - port C bits 0,5 falling edge interrupt
// RL7 - port C bit 7 rising edge interrupt
// RL8 - port C edge interrupt wakes idle device
// RL9 - external interrupt on falling edge only
// RL10 - port C bits 2,3 open-drain, never high
// RL11 - timer inputs plain, no pull-high
// RL12 - inputs read pin level, latches drive outputs
// RL13 - edges compare current and previous samples
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/10ps
module phone_mcu_io_ports #(
  parameter int PORT_W = 8,
  parameter int PE_W   = 4
) (
  // clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst_n,
  // apb slave
  input  wire io_ports_pkg::apb_req_t   apbReq,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr,
  // port a
  input  wire logic [PORT_W-1:0]        wakeupCapablePortPinsIn,
  output logic [PORT_W-1:0]             wakeupCapablePortPinsOut,
  output logic [PORT_W-1:0]             wakeupCapablePortPinsOe,
  output logic [PORT_W-1:0]             wakeupCapablePortPinsPu,
  // port c, bits 2 and 3 are the open-drain lines
  input  wire logic [PORT_W-1:0]        portCIn,
  output logic [PORT_W-1:0]             portCOut,
  output logic [PORT_W-1:0]             portCOe,
  output logic [PORT_W-1:0]             portCPu,
  // port d
  input  wire logic [PORT_W-1:0]        nibblePullupPortPinsIn,
  output logic [PORT_W-1:0]             nibblePullupPortPinsOut,
  output logic [PORT_W-1:0]             nibblePullupPortPinsOe,
  output logic [PORT_W-1:0]             nibblePullupPortPinsPu,
  // port e
  input  wire logic [PE_W-1:0]          fourBitPortPinsIn,
  output logic [PE_W-1:0]               fourBitPortPinsOut,
  output logic [PE_W-1:0]               fourBitPortPinsOe,
  output logic [PE_W-1:0]               fourBitPortPinsPu,
  // dedicated inputs
  input  wire logic                     extIntIn_n,
  input  wire logic                     timerZeroExtInput,
  input  wire logic                     timerOneExtInput,
  output logic                          timerZeroLevel,
  output logic                          timerOneLevel,
  // system
  output logic                          irq,
  output logic                          idleMode,
  output logic                          wakeUp
);
  import io_ports_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // output pins read back their latch, input pins their sampled level
  function automatic logic [PORT_W-1:0] pinView(input logic [PORT_W-1:0] lat,
                                                input logic [PORT_W-1:0] oe,
                                                input logic [PORT_W-1:0] smp);
    pinView = (lat & oe) | (smp & ~oe);
  endfunction

  function automatic logic [31:0] zext8(input logic [PORT_W-1:0] v);
    zext8 = {{(32-PORT_W){1'b0}}, v};
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [PORT_W-1:0] paLatchReg, paDirReg, paPullReg, paWakeReg;
  logic [PORT_W-1:0] pcLatchReg, pcDirReg, pcPullReg;
  logic [PORT_W-1:0] pdLatchReg, pdDirReg;
  logic [PE_W-1:0]   peLatchReg, peDirReg;
  logic [2:0]        dePullReg;
  logic [ST_W-1:0]   statusReg, enableReg;
  logic [PORT_W-1:0] paSampReg, paPrevReg, pcSampReg, pcPrevReg, pdSampReg;
  logic [PE_W-1:0]   peSampReg;
  logic              extSampReg, extPrevReg, idleReg;
  logic              busAccess, busAccept, busWrite;
  logic [7:0]        busAddr;
  logic [31:0]       busData;
  logic [PORT_W-1:0] pcFall, pcRise, paChange;
  logic              portCEdge, extFall, paWakeHit, wakeEvent;
  logic [ST_W-1:0]   statusNext, clearMask;

  assign busAddr   = apbReq.paddr;
  assign busData   = apbReq.pwdata;
  assign busAccess = apbReq.psel & apbReq.penable;
  assign busAccept = busAccess & pready;
  assign busWrite  = busAccept & apbReq.pwrite;

  // ---------------------------------------------------------------
  // bus slave: one wait state, data and error prepared meanwhile
  // ---------------------------------------------------------------
  logic [31:0] readMux;
  logic        addrOk;

  always_comb begin
    readMux = 32'h0000_0000;
    addrOk  = 1'b1;
    unique case (busAddr)
      OFF_A_DATA:  readMux = zext8(pinView(paLatchReg, paDirReg, paSampReg)); // see RL12
      OFF_A_DIR:   readMux = zext8(paDirReg);
      OFF_C_DATA:  readMux = zext8(pinView(pcLatchReg, pcDirReg, pcSampReg));
      OFF_C_DIR:   readMux = zext8(pcDirReg);
      OFF_D_DATA:  readMux = zext8(pinView(pdLatchReg, pdDirReg, pdSampReg));
      OFF_D_DIR:   readMux = zext8(pdDirReg);
      OFF_E_DATA:  readMux = {28'h0, (peLatchReg & peDirReg) | (peSampReg & ~peDirReg)};
      OFF_E_DIR:   readMux = {28'h0, peDirReg};
      OFF_A_PULL:  readMux = zext8(paPullReg);
      OFF_A_WAKE:  readMux = zext8(paWakeReg);
      OFF_C_PULL:  readMux = zext8(pcPullReg);
      OFF_DE_PULL: readMux = {29'h0, dePullReg};
      OFF_STATUS:  readMux = {29'h0, statusReg};
      OFF_CLEAR:   readMux = 32'h0000_0000;
      OFF_ENABLE:  readMux = {29'h0, enableReg};
      OFF_CTRL:    readMux = {31'h0, idleReg};
      OFF_LEVELS:  readMux = {29'h0, extSampReg, timerOneLevel, timerZeroLevel};
      default:     addrOk  = 1'b0;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= busAccess & ~pready;
      prdata  <= (busAccess & ~pready & ~apbReq.pwrite) ? readMux : 32'h0000_0000;
      pslverr <= busAccess & ~pready & ~addrOk;
    end
  end

  // ---------------------------------------------------------------
  // port latches, directions and pull-high options
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      paLatchReg <= DATA_RST;
      paDirReg   <= DIR_RST;
      pcLatchReg <= PC_LAT_RST;
      pcDirReg   <= DIR_RST;
      pdLatchReg <= DATA_RST;
      pdDirReg   <= DIR_RST;
      peLatchReg <= DATA_RST[PE_W-1:0];
      peDirReg   <= DIR_RST[PE_W-1:0];
    end else if (busWrite) begin
      unique case (busAddr)
        OFF_A_DATA: paLatchReg <= busData[PORT_W-1:0]; // see RL12
        OFF_A_DIR:  paDirReg   <= busData[PORT_W-1:0]; // see RL2
        OFF_C_DATA: pcLatchReg <= busData[PORT_W-1:0];
        OFF_C_DIR:  pcDirReg   <= busData[PORT_W-1:0] & ~PC_OD_MASK; // see RL10
        OFF_D_DATA: pdLatchReg <= busData[PORT_W-1:0];
        OFF_D_DIR:  pdDirReg   <= busData[PORT_W-1:0];
        OFF_E_DATA: peLatchReg <= busData[PE_W-1:0];
        OFF_E_DIR:  peDirReg   <= busData[PE_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      paPullReg <= CFG_RST;
      paWakeReg <= CFG_RST;
      pcPullReg <= CFG_RST;
      dePullReg <= 3'h0;
    end else if (busWrite) begin
      unique case (busAddr)
        OFF_A_PULL:  paPullReg <= busData[PORT_W-1:0]; // see RL3
        OFF_A_WAKE:  paWakeReg <= busData[PORT_W-1:0]; // see RL1
        OFF_C_PULL:  pcPullReg <= busData[PORT_W-1:0] & ~PC_OD_MASK; // see RL3
        OFF_DE_PULL: dePullReg <= busData[2:0];
        default: ;
      endcase
    end
  end

  // pin drivers: everything leaves through a flop, one cycle behind the latch
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wakeupCapablePortPinsOut <= DATA_RST;
      wakeupCapablePortPinsOe  <= DIR_RST;
      wakeupCapablePortPinsPu  <= CFG_RST;
      portCOut                 <= DATA_RST;
      portCOe                  <= DIR_RST;
      portCPu                  <= CFG_RST;
      nibblePullupPortPinsOut  <= DATA_RST;
      nibblePullupPortPinsOe   <= DIR_RST;
      nibblePullupPortPinsPu   <= CFG_RST;
      fourBitPortPinsOut       <= DATA_RST[PE_W-1:0];
      fourBitPortPinsOe        <= DIR_RST[PE_W-1:0];
      fourBitPortPinsPu        <= CFG_RST[PE_W-1:0];
    end else begin
      wakeupCapablePortPinsOut <= paLatchReg;
      wakeupCapablePortPinsOe  <= paDirReg; // see RL2
      wakeupCapablePortPinsPu  <= paPullReg;
      // open-drain lines only pull low: enable follows the inverted latch
      portCOut                 <= pcLatchReg & ~PC_OD_MASK; // see RL10
      portCOe                  <= pcDirReg | (~pcLatchReg & PC_OD_MASK); // see RL10
      portCPu                  <= pcPullReg;
      nibblePullupPortPinsOut  <= pdLatchReg;
      nibblePullupPortPinsOe   <= pdDirReg;
      nibblePullupPortPinsPu   <= {{4{dePullReg[PD_PU_HI]}}, {4{dePullReg[PD_PU_LO]}}}; // see RL4
      fourBitPortPinsOut       <= peLatchReg;
      fourBitPortPinsOe        <= peDirReg;
      fourBitPortPinsPu        <= {PE_W{dePullReg[PE_PU]}}; // see RL5
    end
  end

  // ---------------------------------------------------------------
  // input sampling and edge detection
  // ---------------------------------------------------------------
  // timer and interrupt inputs have no pull-high output at all
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      paSampReg      <= 8'h00;
      paPrevReg      <= 8'h00;
      pcSampReg      <= 8'h00;
      pcPrevReg      <= 8'h00;
      pdSampReg      <= 8'h00;
      peSampReg      <= 4'h0;
      extSampReg     <= 1'b1;
      extPrevReg     <= 1'b1;
      timerZeroLevel <= 1'b0;
      timerOneLevel  <= 1'b0;
    end else begin
      paSampReg      <= wakeupCapablePortPinsIn;
      paPrevReg      <= paSampReg;
      pcSampReg      <= portCIn;
      pcPrevReg      <= pcSampReg; // see RL13
      pdSampReg      <= nibblePullupPortPinsIn;
      peSampReg      <= fourBitPortPinsIn;
      extSampReg     <= extIntIn_n;
      extPrevReg     <= extSampReg;
      timerZeroLevel <= timerZeroExtInput; // see RL11
      timerOneLevel  <= timerOneExtInput; // see RL11
    end
  end

  assign pcFall    = pcPrevReg & ~pcSampReg; // see RL13
  assign pcRise    = ~pcPrevReg & pcSampReg;
  assign portCEdge = pcFall[PC_FALL_A] | pcFall[PC_FALL_B] | pcRise[PC_RISE]; // see RL6, RL7
  assign extFall   = extPrevReg & ~extSampReg; // see RL9
  // a wake pin only counts while it is an input
  assign paChange  = (paPrevReg ^ paSampReg) & paWakeReg & ~paDirReg;
  assign paWakeHit = |paChange; // see RL1
  assign wakeEvent = idleReg & (paWakeHit | (portCEdge & enableReg[ST_PORTC])); // see RL8

  // ---------------------------------------------------------------
  // interrupt status, enable and idle control
  // ---------------------------------------------------------------
  assign clearMask = (busWrite && busAddr == OFF_CLEAR) ? busData[ST_W-1:0] : 3'h0;

  // a new event in the clear cycle survives: set is applied after clear
  always_comb begin
    statusNext = statusReg & ~clearMask;
    statusNext[ST_PORTC]  = statusNext[ST_PORTC] | portCEdge; // see RL6, RL7
    statusNext[ST_EXTINT] = statusNext[ST_EXTINT] | extFall; // see RL9
    statusNext[ST_WAKE]   = statusNext[ST_WAKE] | wakeEvent;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      statusReg <= 3'h0;
      enableReg <= 3'h0;
      irq       <= 1'b0;
    end else begin
      statusReg <= statusNext;
      if (busWrite && busAddr == OFF_ENABLE) begin
        enableReg <= busData[ST_W-1:0];
      end
      irq <= |(statusReg & enableReg);
    end
  end

  // wake wins over a software write in the same cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      idleReg  <= 1'b0;
      idleMode <= 1'b0;
      wakeUp   <= 1'b0;
    end else begin
      if (wakeEvent) begin
        idleReg <= 1'b0; // see RL8
      end else if (busWrite && busAddr == OFF_CTRL) begin
        idleReg <= busData[CTRL_IDLE];
      end
      idleMode <= idleReg & ~wakeEvent;
      wakeUp   <= wakeEvent;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_od_never_high: assert property (1'b1 |=> (portCOut & PC_OD_MASK) == 8'h00) // see RL10
    else $error("open-drain line driven high");
  a_pc_low_edge: assert property ((pcFall[PC_FALL_A] || pcFall[PC_FALL_B])
                                  |=> statusReg[ST_PORTC]) // see RL6
    else $error("port c falling edge lost");
  a_pc_rise_edge: assert property (pcRise[PC_RISE] |=> statusReg[ST_PORTC]) // see RL7
    else $error("port c rising edge lost");
  a_idle_wake: assert property ((idleReg && enableReg[ST_PORTC] && portCEdge)
                                |=> wakeUp && !idleReg ##1 !idleMode) // see RL8
    else $error("port c edge did not wake");
  a_pa_wake: assert property ((idleReg && paWakeHit) |=> wakeUp && !idleReg) // see RL1
    else $error("port a wake missed");
  a_ext_falls: assert property ($fell(extSampReg) |=> statusReg[ST_EXTINT]) // see RL9
    else $error("external falling edge lost");
  a_ext_only_fall: assert property ((!statusReg[ST_EXTINT] && !extFall)
                                    |=> !statusReg[ST_EXTINT]) // see RL9
    else $error("external flag set without falling edge");
  a_nibble_pull: assert property (nibblePullupPortPinsPu[3:0] inside {4'h0, 4'hF}
                                  && nibblePullupPortPinsPu[7:4] inside {4'h0, 4'hF}) // see RL4
    else $error("port d nibble pull split");
  a_port_e_pull: assert property (fourBitPortPinsPu inside {4'h0, 4'hF}) // see RL5
    else $error("port e pull split");
  a_dir_write: assert property ((busWrite && busAddr == OFF_A_DIR)
                                |=> ##1 wakeupCapablePortPinsOe == $past(busData[7:0], 2)) // see RL2
    else $error("direction write not driven");
  a_pc_pull_mask: assert property ((portCPu & PC_OD_MASK) == 8'h00) // see RL3
    else $error("pull-high on open-drain line");
  a_timer_level: assert property (timerZeroLevel == $past(timerZeroExtInput)
                                  && timerOneLevel == $past(timerOneExtInput)) // see RL11
    else $error("timer input level wrong");
  a_apb_wait: assert property ((busAccess && !pready) |=> pready ##1 !pready) // bus wait state, a design decision made here
    else $error("bus answer timing wrong");

  c_port_c_irq: cover property (enableReg[ST_PORTC] && portCEdge ##2 irq);
  c_ext_irq:    cover property (extFall ##1 statusReg[ST_EXTINT]);
  c_idle_wake:  cover property (idleReg ##[1:20] wakeUp);
  c_od_release: cover property ((portCOe & PC_OD_MASK) == PC_OD_MASK ##1 (portCOe & PC_OD_MASK) == 8'h00);

endmodule

// file: shared/io_ports_pkg.sv
package io_ports_pkg;

  // ---------------------------------------------------------------
  // bus carrier
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_A_DATA  = 8'h00;
  localparam logic [7:0] OFF_A_DIR   = 8'h04;
  localparam logic [7:0] OFF_C_DATA  = 8'h08;
  localparam logic [7:0] OFF_C_DIR   = 8'h0C;
  localparam logic [7:0] OFF_D_DATA  = 8'h10;
  localparam logic [7:0] OFF_D_DIR   = 8'h14;
  localparam logic [7:0] OFF_E_DATA  = 8'h18;
  localparam logic [7:0] OFF_E_DIR   = 8'h1C;
  localparam logic [7:0] OFF_A_PULL  = 8'h20;
  localparam logic [7:0] OFF_A_WAKE  = 8'h24;
  localparam logic [7:0] OFF_C_PULL  = 8'h28;
  localparam logic [7:0] OFF_DE_PULL = 8'h2C;
  localparam logic [7:0] OFF_STATUS  = 8'h30;
  localparam logic [7:0] OFF_CLEAR   = 8'h34;
  localparam logic [7:0] OFF_ENABLE  = 8'h38;
  localparam logic [7:0] OFF_CTRL    = 8'h3C;
  localparam logic [7:0] OFF_LEVELS  = 8'h40;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int         ST_W       = 3;
  localparam int         ST_PORTC   = 0;
  localparam int         ST_EXTINT  = 1;
  localparam int         ST_WAKE    = 2;
  localparam int         PC_FALL_A  = 0;
  localparam int         PC_FALL_B  = 5;
  localparam int         PC_RISE    = 7;
  localparam int         PD_PU_LO   = 0;
  localparam int         PD_PU_HI   = 1;
  localparam int         PE_PU      = 2;
  localparam int         CTRL_IDLE  = 0;
  localparam int         LV_TIMER_ZERO_EXT_INPUT    = 0;
  localparam int         LV_TIMER_ONE_EXT_INPUT    = 1;
  localparam int         LV_EXTINT  = 2;
  localparam logic [7:0] PC_OD_MASK = 8'h0C;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] DATA_RST   = 8'h00;
  localparam logic [7:0] DIR_RST    = 8'h00;
  localparam logic [7:0] PC_LAT_RST = 8'h0C;
  localparam logic [7:0] CFG_RST    = 8'h00;

endpackage

// file: testbench/board_model.sv
`timescale 1ns/10ps
module board_model #(
  parameter int W = 8
) (
  // clock
  input  wire logic         clock,
  // device side
  input  wire logic [W-1:0] pinOut,
  input  wire logic [W-1:0] pinOe,
  input  wire logic [W-1:0] pinPu,
  // board side
  input  wire logic [W-1:0] extEn,
  input  wire logic [W-1:0] extVal,
  output logic      [W-1:0] pinIn
);
  // a floating undriven pin keeps flipping so a stale value never passes
  logic [W-1:0] lastReg = '0;

  always_ff @(posedge clock) begin
    lastReg <= pinIn;
  end

  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (pinOe[i]) begin
        pinIn[i] = pinOut[i];
      end else if (extEn[i]) begin
        pinIn[i] = extVal[i];
      end else if (pinPu[i]) begin
        pinIn[i] = 1'b1;
      end else begin
        pinIn[i] = ~lastReg[i];
      end
    end
  end
endmodule

// file: testbench/phone_mcu_io_ports_test.sv
`timescale 1ns/10ps
module phone_mcu_io_ports_test;
  import io_ports_pkg::*;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  apb_req_t    apbReq = '0;
  logic [31:0] prdata, rdat;
  logic        pready, pslverr, lastErr;
  logic [7:0]  aOut, aOe, aPu, aIn, cOut, cOe, cPu, cIn, dOut, dOe, dPu, dIn;
  logic [3:0]  eOut, eOe, ePu, eIn;
  logic [7:0]  extA = 8'h03;
  logic [7:0]  extC = 8'h21;
  logic [7:0]  extD = 8'h5A;
  logic [3:0]  extE = 4'h9;
  logic [7:0]  extEnA = 8'hFF;
  logic [7:0]  extEnC = 8'hFF;
  logic [7:0]  extEnD = 8'hFF;
  logic [3:0]  extEnE = 4'hF;
  logic        extInt_n = 1'b1;
  logic        timer_zero_ext_input = 1'b0;
  logic        timer_one_ext_input = 1'b0;
  logic        tmr0Lvl, tmr1Lvl, irq, idleMode, wakeUp;
  int          miscompares = 0;
  int          cmpCount = 0;

  always #20 clock = ~clock;

  board_model #(.W(8)) uA (.clock(clock), .pinOut(aOut), .pinOe(aOe), .pinPu(aPu),
    .extEn(extEnA), .extVal(extA), .pinIn(aIn));
  board_model #(.W(8)) uC (.clock(clock), .pinOut(cOut), .pinOe(cOe), .pinPu(cPu),
    .extEn(extEnC), .extVal(extC), .pinIn(cIn));
  board_model #(.W(8)) uD (.clock(clock), .pinOut(dOut), .pinOe(dOe), .pinPu(dPu),
    .extEn(extEnD), .extVal(extD), .pinIn(dIn));
  board_model #(.W(4)) uE (.clock(clock), .pinOut(eOut), .pinOe(eOe), .pinPu(ePu),
    .extEn(extEnE), .extVal(extE), .pinIn(eIn));

  phone_mcu_io_ports u_dut (.clock(clock), .rst_n(rst_n), .apbReq(apbReq),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wakeupCapablePortPinsIn(aIn), .wakeupCapablePortPinsOut(aOut),
    .wakeupCapablePortPinsOe(aOe), .wakeupCapablePortPinsPu(aPu),
    .portCIn(cIn), .portCOut(cOut), .portCOe(cOe), .portCPu(cPu),
    .nibblePullupPortPinsIn(dIn), .nibblePullupPortPinsOut(dOut),
    .nibblePullupPortPinsOe(dOe), .nibblePullupPortPinsPu(dPu),
    .fourBitPortPinsIn(eIn), .fourBitPortPinsOut(eOut),
    .fourBitPortPinsOe(eOe), .fourBitPortPinsPu(ePu),
    .extIntIn_n(extInt_n), .timerZeroExtInput(timer_zero_ext_input), .timerOneExtInput(timer_one_ext_input),
    .timerZeroLevel(tmr0Lvl), .timerOneLevel(tmr1Lvl),
    .irq(irq), .idleMode(idleMode), .wakeUp(wakeUp));

  // ----
  // helpers
  // ----
  task automatic final_report;
    $display("compares %0d miscompares %0d", cmpCount, miscompares);
    if (miscompares == 0 && cmpCount > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    cmpCount++;
    if (got !== ex) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // signals move just after a rising edge; pready is sampled at the rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    apbReq <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:a, pwdata:d};
    @(posedge clock);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    lastErr = pslverr;
    apbReq <= '0;
    if (pready !== 1'b1) begin
      miscompares++;
      final_report();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, ex, rdat);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask

  // ----
  // scenarios
  // ----
  task automatic t_dir;
    wr(OFF_A_DIR, 32'h000000F0);
    wr(OFF_A_DATA, 32'h000000A5);
    settle(2);
    chk("aOe", 32'hF0, aOe);
    chk("aPin", 32'hA3, aIn);
    rd(OFF_A_DATA, 32'h000000A3, "aData");
    chk("dOe", 32'h0, dOe);
    rd(OFF_D_DATA, 32'h0000005A, "dData");
    wr(OFF_E_DIR, 32'h00000003);
    wr(OFF_E_DATA, 32'h00000006);
    settle(2);
    chk("eOe", 32'h3, eOe);
    chk("eOut", 32'h6, eOut);
    rd(OFF_E_DATA, 32'h0000000A, "eData");
  endtask

  task automatic t_pull;
    wr(OFF_A_PULL, 32'h0000003C);
    wr(OFF_C_PULL, 32'h000000FF);
    wr(OFF_DE_PULL, 32'h00000001);
    settle(2);
    chk("aPu", 32'h3C, aPu);
    chk("cPu", 32'hF3, cPu);
    chk("dPuLo", 32'h0F, dPu);
    chk("ePuOff", 32'h0, ePu);
    // let port a bits 2 and 3 float so only the pull-high holds them
    @(posedge clock);
    extEnA <= 8'hF3;
    settle(2);
    chk("aPullPin", 32'h3, aIn[3:2]);
    rd(OFF_A_DATA, 32'h000000AF, "aPullRd");
    @(posedge clock);
    extEnA <= 8'hFF;
    wr(OFF_DE_PULL, 32'h00000006);
    settle(2);
    chk("dPuHi", 32'hF0, dPu);
    chk("ePuOn", 32'hF, ePu);
  endtask

  task automatic t_odrain;
    wr(OFF_C_DIR, 32'h0000000C);
    wr(OFF_C_DATA, 32'h00000000);
    settle(2);
    chk("cOeLow", 32'h0C, cOe);
    chk("cOutLow", 32'h0, cOut & 8'h0C);
    wr(OFF_C_DATA, 32'h000000FF);
    settle(2);
    chk("cOeRel", 32'h0, cOe);
    chk("cOutRel", 32'h0, cOut & 8'h0C);
  endtask

  task automatic t_pcirq;
    logic [7:0] pv[6] = '{8'h20, 8'h21, 8'h01, 8'h81, 8'h01, 8'h21};
    logic       ev[6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    logic       en[6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
    for (int i = 0; i < 6; i++) begin
      wr(OFF_ENABLE, {31'h0, en[i]});
      wr(OFF_CLEAR, 32'h00000007);
      @(posedge clock);
      extC <= pv[i];
      settle(5);
      chk("pcIrq", {31'h0, ev[i] & en[i]}, irq);
      rd(OFF_STATUS, {31'h0, ev[i]}, "pcStatus");
    end
  endtask

  task automatic t_extint;
    wr(OFF_ENABLE, 32'h00000002);
    wr(OFF_CLEAR, 32'h00000007);
    @(posedge clock);
    extInt_n <= 1'b0;
    settle(5);
    chk("extIrq", 32'h1, irq);
    rd(OFF_STATUS, 32'h00000002, "extFall");
    wr(OFF_CLEAR, 32'h00000007);
    @(posedge clock);
    extInt_n <= 1'b1;
    settle(5);
    rd(OFF_STATUS, 32'h00000000, "extRise");
  endtask

  task automatic t_wake;
    int n;
    wr(OFF_A_DIR, 32'h00000000);
    wr(OFF_A_WAKE, 32'h00000001);
    wr(OFF_CTRL, 32'h00000001);
    @(posedge clock);
    extA <= 8'h01;
    settle(5);
    chk("idleHeld", 32'h1, idleMode);
    @(posedge clock);
    extA <= 8'h00;
    n = 0;
    while (wakeUp !== 1'b1 && n < 10) begin
      @(negedge clock);
      n++;
    end
    chk("paWake", 32'h1, wakeUp);
    if (wakeUp !== 1'b1) begin
      final_report();
    end
    settle(1);
    chk("idleLeft", 32'h0, idleMode);
    wr(OFF_ENABLE, 32'h00000001);
    wr(OFF_CTRL, 32'h00000001);
    @(posedge clock);
    extC <= 8'h20;
    n = 0;
    while (wakeUp !== 1'b1 && n < 10) begin
      @(negedge clock);
      n++;
    end
    chk("pcWake", 32'h1, wakeUp);
    if (wakeUp !== 1'b1) begin
      final_report();
    end
    rd(OFF_CTRL, 32'h00000000, "ctrlIdle");
    rd(OFF_STATUS, 32'h00000005, "wakeStatus");
  endtask

  task automatic t_misc;
    @(posedge clock);
    timer_zero_ext_input <= 1'b1;
    settle(2);
    chk("tmr0Lvl", 32'h1, tmr0Lvl);
    chk("tmr1Lvl", 32'h0, tmr1Lvl);
    rd(OFF_LEVELS, 32'h00000005, "levels");
    rd(8'h44, 32'h0, "unmapped");
    chk("slvErr", 32'h1, lastErr);
  endtask

  initial begin
    repeat (15) @(posedge clock);
    @(negedge clock);
    chk("rstOeA", 32'h0, aOe);
    chk("rstOeC", 32'h0, cOe);
    chk("rstIrq", 32'h0, irq);
    @(posedge clock);
    rst_n <= 1'b1;
    rd(OFF_STATUS, 32'h0, "rstStatus");
    t_dir();
    t_pull();
    t_odrain();
    t_pcirq();
    t_extint();
    t_wake();
    t_misc();
    final_report();
  end
endmodule
